// file: dbab_buf.sv
// two-entry request buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module dbab_buf #(
    parameter int WIDTH = 65
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 2'h1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

endmodule // dbab_buf

`default_nettype wire

// file: dbab_dn_model.sv
// downstream debug bus slave model for the bridge testbench
`timescale 1ns/1ns
`default_nettype none

module dbab_dn_model #(
    parameter logic [31:0] RD_KEY = 32'h5A5A_C3C3
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // bridge master side
    input  wire logic        sel_i,
    input  wire logic        enable_i,
    input  wire logic        write_i,
    input  wire logic        abort_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic             ready_o,
    output logic             slverr_o,
    output logic      [31:0] rdata_o,
    // scenario controls
    input  wire logic [7:0]  wait_i,
    input  wire logic        err_i,
    // observations
    output logic      [31:0] seen_addr_o,
    output logic      [31:0] seen_wdata_o,
    output logic             seen_write_o,
    output logic             hold_err_o
);
    logic [7:0]  cnt_reg;
    logic [31:0] last_rd_reg;
    logic        access;

    assign access = sel_i & enable_i;
    assign ready_o = access & (cnt_reg == wait_i);
    assign slverr_o = ready_o & err_i;
    // outside the answer the bus shows the inverse of the last word
    assign rdata_o = ready_o ? (addr_i ^ RD_KEY) : ~last_rd_reg;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_reg <= 8'h00;
        else if (!access || abort_i)
            cnt_reg <= 8'h00;
        else if (!ready_o)
            cnt_reg <= cnt_reg + 8'h01;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            last_rd_reg <= 32'h0000_0000;
        else if (ready_o)
            last_rd_reg <= rdata_o;
    end

    // capture in setup, flag any change during access
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            seen_addr_o  <= 32'h0000_0000;
            seen_wdata_o <= 32'h0000_0000;
            seen_write_o <= 1'b0;
            hold_err_o   <= 1'b0;
        end
        else if (sel_i && !enable_i)
        begin
            seen_addr_o  <= addr_i;
            seen_wdata_o <= wdata_i;
            seen_write_o <= write_i;
        end
        else if (access && ({addr_i, wdata_i, write_i} !== {seen_addr_o, seen_wdata_o, seen_write_o}))
            hold_err_o <= 1'b1;
    end
endmodule // dbab_dn_model

`default_nettype wire

// file: dbab_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none

module dbab_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    // level in and out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // first stage read only by the second
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= '0;
            q_reg    <= '0;
        end
        else
        begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule // dbab_sync

`default_nettype wire

// file: dbab_top.sv
// debug bus bridge: constants package and top with slave and master ends
// Summary of operation
// [R1] upstream abort: ready high next cycle
// [R2] enable marks second and later cycles
// [R3] master drives write high, read low
// [R4] downstream write mirrors upstream direction
// [R5] 32-bit address and data forwarded unchanged
// [R6] downstream ready ends the transfer
// [R7] downstream error flags failed transfer
// [R8] downstream read word returned upstream
// [R9] upstream ready high when transfer completes
// [R10] upstream error reflects downstream error
// [R11] select asserted when downstream transfer starts
// [R12] upstream abort propagated as downstream abort
// [R13] write data held for whole transfer
// [R14] clock-activity high unless idle
// [R15] low-power pins only with the option
// [R16] built as slave and master ends
// [R17] ends joined by req, ack, data, abort
// [R18] upstream select addresses this bridge
// [R19] crossings synchronised, data held until handshake
`timescale 1ns/1ns
`default_nettype none

package dbab_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int FWD_W  = ADDR_W + DATA_W + 1;
    localparam int REV_W  = DATA_W + 1;
    localparam int FWD_WRITE_BIT = FWD_W - 1;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ABORT} dbab_sstate_e;
    typedef enum logic [1:0] {M_IDLE, M_SETUP, M_ACCESS, M_ACK} dbab_mstate_e;
endpackage // dbab_pkg

module dbab_top #(
    parameter bit LOW_POWER_HANDSHAKE_OPTION = 1'b1
) (
    // clock and reset
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_b_i,
    // upstream port
    input  wire logic                        up_sel_i,
    input  wire logic                        up_enable_i,
    input  wire logic                        up_write_i,
    input  wire logic                        up_abort_i,
    input  wire logic [dbab_pkg::ADDR_W-1:0] up_addr_i,
    input  wire logic [dbab_pkg::DATA_W-1:0] up_wdata_i,
    output logic                             up_ready_o,
    output logic                             up_slverr_o,
    output logic      [dbab_pkg::DATA_W-1:0] up_rdata_o,
    // downstream port
    input  wire logic                        dn_ready_i,
    input  wire logic                        dn_slverr_i,
    input  wire logic [dbab_pkg::DATA_W-1:0] dn_rdata_i,
    output logic                             dn_sel_o,
    output logic                             dn_enable_o,
    output logic                             dn_write_o,
    output logic                             dn_abort_o,
    output logic      [dbab_pkg::ADDR_W-1:0] dn_addr_o,
    output logic      [dbab_pkg::DATA_W-1:0] dn_wdata_o,
    // low-power clock handshake
    input  wire logic                        csysreq_i,
    output logic                             csysack_o,
    output logic                             cactive_o
);

    // =========================================================
    // crossing signals between the two ends and the synced low-power request
    // =========================================================
    logic                       req_async_reg;
    logic                       ack_async_reg;
    logic                       abort_req_async_reg;
    logic [dbab_pkg::FWD_W-1:0] fwd_data_async;
    logic [dbab_pkg::REV_W-1:0] rev_data_async_reg;
    logic                       req_sync;
    logic                       ack_sync;
    logic                       abort_sync;
    logic                       lp_req_sync;
    logic                       lp_release_sync;

    dbab_sync #(.WIDTH(1)) u_req_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .d_i        (req_async_reg),
        .q_o        (req_sync)
    ); // [R19]

    dbab_sync #(.WIDTH(1)) u_ack_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .d_i        (ack_async_reg),
        .q_o        (ack_sync)
    ); // [R19]

    dbab_sync #(.WIDTH(1)) u_abort_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .d_i        (abort_req_async_reg),
        .q_o        (abort_sync)
    ); // [R19]

    dbab_sync #(.WIDTH(1)) u_lp_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .d_i        (!csysreq_i),
        .q_o        (lp_release_sync)
    );

    // synced as its inverse so that reset reads as clock wanted
    assign lp_req_sync = !lp_release_sync;

    // =========================================================
    // slave end: upstream port and request buffer [R16]
    // =========================================================
    dbab_pkg::dbab_sstate_e     s_state_reg;
    logic                       buf_in_ready;
    logic                       buf_out_valid;
    logic                       buf_pop;
    logic                       s_push;
    logic                       s_done;
    logic [dbab_pkg::FWD_W-1:0] buf_in_data;

    assign buf_in_data = {up_write_i, up_addr_i, up_wdata_i}; // [R5]
    // taken only while idle and not in a ready cycle; a full buffer stalls it
    assign s_push = (s_state_reg == dbab_pkg::S_IDLE) && up_sel_i && !up_abort_i
                    && !up_ready_o && buf_in_ready; // [R18]
    assign s_done  = req_async_reg && ack_sync; // [R17]
    assign buf_pop = s_done;

    dbab_buf #(.WIDTH(dbab_pkg::FWD_W)) u_fwd_buf (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (s_push),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (fwd_data_async)
    );

    // four-phase request toward the master end
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            req_async_reg <= 1'b0;
        end
        else if (s_done)
        begin
            req_async_reg <= 1'b0;
        end
        else if (buf_out_valid && !ack_sync)
        begin
            req_async_reg <= 1'b1; // [R17]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_state_reg <= dbab_pkg::S_IDLE;
        end
        else
        begin
            case (s_state_reg)
                dbab_pkg::S_IDLE:
                begin
                    if (s_push)
                    begin
                        s_state_reg <= dbab_pkg::S_WAIT;
                    end
                end
                dbab_pkg::S_WAIT:
                begin
                    if (up_abort_i)
                    begin
                        s_state_reg <= s_done ? dbab_pkg::S_IDLE : dbab_pkg::S_ABORT;
                    end
                    else if (s_done)
                    begin
                        s_state_reg <= dbab_pkg::S_IDLE;
                    end
                end
                dbab_pkg::S_ABORT:
                begin
                    if (s_done)
                    begin
                        s_state_reg <= dbab_pkg::S_IDLE;
                    end
                end
                default:
                begin
                    s_state_reg <= dbab_pkg::S_IDLE;
                end
            endcase
        end
    end

    // abort request stays up until the aborted transfer has drained
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            abort_req_async_reg <= 1'b0;
        end
        else if (s_state_reg == dbab_pkg::S_WAIT && up_abort_i && !s_done)
        begin
            abort_req_async_reg <= 1'b1; // [R12]
        end
        else if (s_state_reg == dbab_pkg::S_ABORT && s_done)
        begin
            abort_req_async_reg <= 1'b0;
        end
    end

    // upstream response
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            up_ready_o  <= 1'b0;
            up_slverr_o <= 1'b0;
            up_rdata_o  <= dbab_pkg::RDATA_RST;
        end
        else
        begin
            up_ready_o  <= up_abort_i
                           || (s_state_reg == dbab_pkg::S_WAIT && s_done); // [R1] [R9]
            up_slverr_o <= !up_abort_i && s_state_reg == dbab_pkg::S_WAIT && s_done
                           && rev_data_async_reg[dbab_pkg::DATA_W]; // [R10]
            if (s_state_reg == dbab_pkg::S_WAIT && s_done)
            begin
                up_rdata_o <= rev_data_async_reg[dbab_pkg::DATA_W-1:0]; // [R8]
            end
        end
    end

    // =========================================================
    // master end: downstream port
    // =========================================================
    dbab_pkg::dbab_mstate_e m_state_reg;
    logic                   m_abort_now;

    assign m_abort_now = abort_sync && (m_state_reg == dbab_pkg::M_SETUP
                         || m_state_reg == dbab_pkg::M_ACCESS);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            m_state_reg   <= dbab_pkg::M_IDLE;
            ack_async_reg <= 1'b0;
        end
        else
        begin
            case (m_state_reg)
                dbab_pkg::M_IDLE:
                begin
                    if (req_sync)
                    begin
                        m_state_reg <= dbab_pkg::M_SETUP; // [R11]
                    end
                end
                dbab_pkg::M_SETUP:
                begin
                    m_state_reg <= m_abort_now ? dbab_pkg::M_ACK : dbab_pkg::M_ACCESS;
                    ack_async_reg <= m_abort_now;
                end
                dbab_pkg::M_ACCESS:
                begin
                    if (m_abort_now || dn_ready_i)
                    begin
                        m_state_reg   <= dbab_pkg::M_ACK; // [R6]
                        ack_async_reg <= 1'b1;
                    end
                end
                dbab_pkg::M_ACK:
                begin
                    if (!req_sync)
                    begin
                        m_state_reg   <= dbab_pkg::M_IDLE;
                        ack_async_reg <= 1'b0;
                    end
                end
                default:
                begin
                    m_state_reg   <= dbab_pkg::M_IDLE;
                    ack_async_reg <= 1'b0;
                end
            endcase
        end
    end

    // downstream control and captured request
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dn_sel_o    <= 1'b0;
            dn_enable_o <= 1'b0;
            dn_abort_o  <= 1'b0;
            dn_write_o  <= 1'b0;
            dn_addr_o   <= '0;
            dn_wdata_o  <= '0;
        end
        else
        begin
            dn_abort_o <= m_abort_now; // [R12]
            if (m_state_reg == dbab_pkg::M_IDLE && req_sync)
            begin
                dn_sel_o   <= 1'b1; // [R11]
                dn_write_o <= fwd_data_async[dbab_pkg::FWD_WRITE_BIT]; // [R4]
                dn_addr_o  <= fwd_data_async[dbab_pkg::FWD_W-2 -: dbab_pkg::ADDR_W]; // [R5]
                dn_wdata_o <= fwd_data_async[dbab_pkg::DATA_W-1:0]; // [R5] [R13]
            end
            else if (m_abort_now || (m_state_reg == dbab_pkg::M_ACCESS && dn_ready_i))
            begin
                dn_sel_o    <= 1'b0;
                dn_enable_o <= 1'b0;
            end
            else if (m_state_reg == dbab_pkg::M_SETUP)
            begin
                dn_enable_o <= 1'b1; // [R2]
            end
        end
    end

    // response held stable while acknowledge is up
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rev_data_async_reg <= '0;
        end
        else if (m_state_reg == dbab_pkg::M_ACCESS && !m_abort_now && dn_ready_i)
        begin
            rev_data_async_reg <= {dn_slverr_i, dn_rdata_i}; // [R7] [R19]
        end
    end

    // =========================================================
    // low-power clock handshake
    // =========================================================
    logic busy;
    logic csysack_reg;

    assign busy = (s_state_reg != dbab_pkg::S_IDLE) || buf_out_valid || req_async_reg
                  || ack_async_reg || (m_state_reg != dbab_pkg::M_IDLE) || up_sel_i;

    // powerdown granted only while idle
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            csysack_reg <= 1'b1;
        end
        else if (lp_req_sync || !busy)
        begin
            csysack_reg <= lp_req_sync;
        end
    end

    assign csysack_o = LOW_POWER_HANDSHAKE_OPTION ? csysack_reg : 1'b0; // [R15]
    assign cactive_o = LOW_POWER_HANDSHAKE_OPTION ? busy : 1'b1; // [R14] [R15]

    // =========================================================
    // checks
    // =========================================================
    sequence s_fwd_start;
        m_state_reg == dbab_pkg::M_IDLE && req_sync;
    endsequence

    sequence s_setup_access;
        dn_sel_o && !dn_enable_o ##1 dn_sel_o && dn_enable_o;
    endsequence

    property p_abort_ready;
        @(posedge core_clk_i) disable iff (!rst_b_i) up_abort_i |=> up_ready_o;
    endproperty
    a_abort_ready: assert property (p_abort_ready) else $error("no ready after abort"); // [R1]

    property p_setup_access;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            s_fwd_start ##1 !m_abort_now |-> s_setup_access;
    endproperty
    a_setup_access: assert property (p_setup_access) else $error("bad setup/access"); // [R2]

    property p_fwd_copy;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            s_fwd_start |=> dn_sel_o && {dn_write_o, dn_addr_o, dn_wdata_o}
                            == $past(fwd_data_async);
    endproperty
    a_fwd_copy: assert property (p_fwd_copy) else $error("forward data mismatch"); // [R4]

    property p_data_hold;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            dn_sel_o && $past(dn_sel_o) |-> $stable(dn_wdata_o) && $stable(dn_addr_o)
                                            && $stable(dn_write_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved mid transfer"); // [R13]

    property p_read_return;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            s_state_reg == dbab_pkg::S_WAIT && s_done && !up_abort_i
            |=> up_ready_o && up_rdata_o == $past(rev_data_async_reg[dbab_pkg::DATA_W-1:0])
                && up_slverr_o == $past(rev_data_async_reg[dbab_pkg::DATA_W]);
    endproperty
    a_read_return: assert property (p_read_return) else $error("wrong response"); // [R8]

    property p_ready_cause;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            up_ready_o |-> $past(up_abort_i)
                           || $past(s_done && s_state_reg == dbab_pkg::S_WAIT);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("spurious ready"); // [R9]

    property p_abort_prop;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            m_abort_now |=> dn_abort_o && !dn_sel_o && ack_async_reg;
    endproperty
    a_abort_prop: assert property (p_abort_prop) else $error("abort not passed on"); // [R12]

    property p_cactive;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            (m_state_reg != dbab_pkg::M_IDLE || req_async_reg) |-> cactive_o;
    endproperty
    a_cactive: assert property (p_cactive) else $error("clock dropped while busy"); // [R14]

    property p_fwd_stable;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            req_async_reg && !ack_sync |=> $stable(fwd_data_async);
    endproperty
    a_fwd_stable: assert property (p_fwd_stable) else $error("forward data changed"); // [R19]

    property p_ack_bound;
        @(posedge core_clk_i) disable iff (!rst_b_i)
            $rose(req_async_reg) |-> ##[2:4] m_state_reg != dbab_pkg::M_IDLE;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("request not seen"); // [R17]

endmodule // dbab_top

`default_nettype wire

// file: dbab_top_tb.sv
// self-checking testbench for the debug bus bridge top
`timescale 1ns/1ns
`default_nettype none

module dbab_top_tb;
    localparam logic [31:0] RD_KEY = 32'h5A5A_C3C3;
    logic core_clk_i = 1'b0;
    logic rst_b_i, up_sel_i, up_enable_i, up_write_i, up_abort_i, csysreq_i;
    logic [31:0] up_addr_i, up_wdata_i, up_rdata_o, dn_rdata_i, dn_addr_o, dn_wdata_o;
    logic up_ready_o, up_slverr_o, dn_ready_i, dn_slverr_i, dn_sel_o, dn_enable_o;
    logic dn_write_o, dn_abort_o, csysack_o, cactive_o, dn_err, m_write, m_hold;
    logic [7:0]  dn_wait;
    logic [31:0] m_addr, m_wdata, rd;
    logic        er;
    int          err_total = 0;
    int          checks = 0;

    always #2 core_clk_i = ~core_clk_i;

    dbab_top dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .up_sel_i(up_sel_i),
        .up_enable_i(up_enable_i), .up_write_i(up_write_i), .up_abort_i(up_abort_i),
        .up_addr_i(up_addr_i), .up_wdata_i(up_wdata_i), .up_ready_o(up_ready_o),
        .up_slverr_o(up_slverr_o), .up_rdata_o(up_rdata_o), .dn_ready_i(dn_ready_i),
        .dn_slverr_i(dn_slverr_i), .dn_rdata_i(dn_rdata_i), .dn_sel_o(dn_sel_o),
        .dn_enable_o(dn_enable_o), .dn_write_o(dn_write_o), .dn_abort_o(dn_abort_o),
        .dn_addr_o(dn_addr_o), .dn_wdata_o(dn_wdata_o), .csysreq_i(csysreq_i),
        .csysack_o(csysack_o), .cactive_o(cactive_o)
    );

    dbab_dn_model #(.RD_KEY(RD_KEY)) dn (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sel_i(dn_sel_o),
        .enable_i(dn_enable_o), .write_i(dn_write_o), .abort_i(dn_abort_o),
        .addr_i(dn_addr_o), .wdata_i(dn_wdata_o), .ready_o(dn_ready_i),
        .slverr_o(dn_slverr_i), .rdata_o(dn_rdata_i), .wait_i(dn_wait), .err_i(dn_err),
        .seen_addr_o(m_addr), .seen_wdata_o(m_wdata), .seen_write_o(m_write),
        .hold_err_o(m_hold)
    );

    // ========================================
    // checking and closing
    task automatic test_done();
    begin
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // ========================================
    // one upstream transfer, sel held until ready
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [7:0] w, input logic e);
        int n;
    begin
        dn_wait <= w;
        dn_err <= e;
        up_write_i <= wr;
        up_addr_i <= a;
        up_wdata_i <= d;
        up_sel_i <= 1'b1;
        @(posedge core_clk_i);
        up_enable_i <= 1'b1;
        for (n = 0; n < 80 && up_ready_o !== 1'b1; n++)
        begin
            @(posedge core_clk_i);
            chk1(cactive_o, 1'b1);
        end
        if (n == 80)
        begin
            err_total++;
            test_done();
        end
        rd = up_rdata_o;
        er = up_slverr_o;
        up_sel_i <= 1'b0;
        up_enable_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        chk1(m_hold, 1'b0);
    end
    endtask

    // ========================================
    // scenarios
    task automatic t_write();
    begin
        chk1(up_ready_o, 1'b0);
        chk1(dn_sel_o, 1'b0);
        xfer(1'b1, 32'hFFFF_FFFC, 32'hFFFF_FFFF, 8'h00, 1'b0);
        chk(m_addr, 32'hFFFF_FFFC);
        chk(m_wdata, 32'hFFFF_FFFF);
        chk1(m_write, 1'b1);
        chk1(er, 1'b0);
        xfer(1'b1, 32'h0000_0000, 32'h1234_5678, 8'h04, 1'b0);
        chk(m_addr, 32'h0000_0000);
        chk(m_wdata, 32'h1234_5678);
    end
    endtask

    task automatic t_read();
        int i;
        logic [31:0] a;
    begin
        for (i = 0; i < 3; i++)
        begin
            a = 32'h0000_1000 + 32'(i * 4);
            xfer(1'b0, a, 32'hDEAD_BEEF, 8'(i * 3), 1'b0);
            chk(rd, a ^ RD_KEY);
            chk1(m_write, 1'b0);
            chk1(er, 1'b0);
        end
    end
    endtask

    task automatic t_error();
    begin
        xfer(1'b1, 32'h0000_2000, 32'h0000_00A5, 8'h02, 1'b1);
        chk1(er, 1'b1);
        xfer(1'b0, 32'h0000_2004, 32'h0000_0000, 8'h00, 1'b1);
        chk1(er, 1'b1);
        xfer(1'b0, 32'h0000_2008, 32'h0000_0000, 8'h00, 1'b0);
        chk1(er, 1'b0);
        chk(rd, 32'h0000_2008 ^ RD_KEY);
    end
    endtask

    task automatic t_abort();
        int n;
        logic hit;
    begin
        dn_wait <= 8'hC8;
        dn_err <= 1'b0;
        up_write_i <= 1'b1;
        up_addr_i <= 32'h0000_3000;
        up_sel_i <= 1'b1;
        @(posedge core_clk_i);
        up_enable_i <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        chk1(dn_sel_o, 1'b1);
        up_abort_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk1(up_ready_o, 1'b1);
        chk1(up_slverr_o, 1'b0);
        up_abort_i <= 1'b0;
        up_sel_i <= 1'b0;
        up_enable_i <= 1'b0;
        hit = 1'b0;
        for (n = 0; n < 12; n++)
        begin
            @(posedge core_clk_i);
            if (dn_abort_o === 1'b1)
                hit = 1'b1;
        end
        chk1(hit, 1'b1);
        chk1(dn_sel_o, 1'b0);
        for (n = 0; n < 30; n++)
        begin
            @(posedge core_clk_i);
            if (up_ready_o !== 1'b0)
                hit = 1'b0;
        end
        chk1(hit, 1'b1);
        xfer(1'b0, 32'h0000_3004, 32'h0000_0000, 8'h01, 1'b0);
        chk(rd, 32'h0000_3004 ^ RD_KEY);
    end
    endtask

    task automatic t_lowpower();
        int n;
    begin
        chk1(cactive_o, 1'b0);
        csysreq_i <= 1'b0;
        for (n = 0; n < 8 && csysack_o !== 1'b0; n++)
            @(posedge core_clk_i);
        chk1(csysack_o, 1'b0);
        csysreq_i <= 1'b1;
        for (n = 0; n < 8 && csysack_o !== 1'b1; n++)
            @(posedge core_clk_i);
        chk1(csysack_o, 1'b1);
    end
    endtask

    // ========================================
    // main sequence
    initial
    begin
        rst_b_i = 1'b0;
        {up_sel_i, up_enable_i, up_write_i, up_abort_i, dn_err} = 5'h00;
        up_addr_i = 32'h0000_0000;
        up_wdata_i = 32'h0000_0000;
        dn_wait = 8'h00;
        csysreq_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        t_write();
        t_read();
        t_error();
        t_abort();
        t_lowpower();
        test_done();
    end
endmodule // dbab_top_tb

`default_nettype wire
